// ===== hdl/nfc_cfg.svh
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH
// How it works
// RL1 - Unique-ID, set and get features are accepted only while the target is idle.
// RL2 - The unique-ID command code puts the target in unique-ID read mode.
// RL3 - Unique-ID command is followed by one 00h address; target then goes busy.
// RL4 - After polling status with 70h the host reissues 00h to read data; this design waits on ready/busy instead.
// RL5 - After the busy time, each read enable toggle outputs one unique-ID byte.
// RL6 - Unique ID is sixteen 32-byte copies: 16 ID bytes, then their complement.
// RL7 - Host XORs both halves; copy is good only if all results are FFh.
// RL8 - Random data read 05h-E0h moves the output pointer during unique-ID output.
// RL9 - On a 16-bit device the upper eight I/O lines are ignored.
// RL10 - One feature address selects four parameter bytes P1 to P4.
// RL11 - Feature settings are volatile and survive a reset command.
// RL12 - ECC on is P1=08h, off is P1=00h at address 90h, then wait.
// RL13 - Feature addresses: 01h timing, 80h drive, 81h busy pull-down, 90h array mode.
// RL14 - Array mode P1: 00h normal, 01h OTP, 03h OTP protect, 08h ECC on.
// RL15 - Array mode bits return to 00h on power cycle.
// RL16 - Set-features code holds the target in set-features mode.
// RL17 - Host waits the address-to-data time, then one parameter per write enable rise.
// RL18 - After four parameters the target is busy for the feature time.
// RL19 - Changing the interface type through timing mode makes the busy time longer.
// RL20 - Get-features code holds the mode; after the address the target goes busy.
// RL21 - Host never issues read status enhanced 78h during get features.
// RL22 - Host reads parameters only after the feature busy time has ended.
// RL23 - Get-features output is P1, P2, P3, P4, one byte per read enable toggle.
// RL24 - Target holds ready/busy low while busy and releases it when done.

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define NFC_CLK_NS        10
`define NFC_CYC(ns)       ((((ns) + `NFC_CLK_NS - 1) / `NFC_CLK_NS) < 1 ? 1 : \
	(((ns) + `NFC_CLK_NS - 1) / `NFC_CLK_NS))
`define NFC_T_WP_NS       20
`define NFC_T_WH_NS       20
`define NFC_T_RP_NS       20
`define NFC_T_REH_NS      20
`define NFC_T_ADL_NS      100
`define NFC_T_WB_NS       100
`define NFC_T_WHR_NS      80
`define NFC_SYNC_LAT      3
`define NFC_WP_CYC        8'(`NFC_CYC(`NFC_T_WP_NS))
`define NFC_WH_CYC        8'(`NFC_CYC(`NFC_T_WH_NS))
`define NFC_RP_CYC        8'(`NFC_CYC(`NFC_T_RP_NS) + `NFC_SYNC_LAT)
`define NFC_REH_CYC       8'(`NFC_CYC(`NFC_T_REH_NS))
`define NFC_ADL_CYC       8'(`NFC_CYC(`NFC_T_ADL_NS))
`define NFC_WB_CYC        8'(`NFC_CYC(`NFC_T_WB_NS))
`define NFC_WHR_CYC       8'(`NFC_CYC(`NFC_T_WHR_NS))

// ----------------------------------------------------------------
// Command and address codes
// ----------------------------------------------------------------
`define NFC_CODE_UID      8'hed
`define NFC_CODE_SET      8'hef
`define NFC_CODE_GET      8'hee
`define NFC_CODE_RND1     8'h05
`define NFC_CODE_RND2     8'he0
`define NFC_UID_ADDR      8'h00
`define NFC_FA_TIMING     8'h01
`define NFC_FA_DRIVE      8'h80
`define NFC_FA_PULLDOWN   8'h81
`define NFC_FA_ARRAY      8'h90
`define NFC_ARR_NORMAL    8'h00
`define NFC_ARR_OTP       8'h01
`define NFC_ARR_OTP_PROT  8'h03
`define NFC_ARR_ECC_ON    8'h08
`define NFC_HALF_BYTES    5'h10
`define NFC_LAST_BYTE     5'h1f

// ----------------------------------------------------------------
// Own registers
// ----------------------------------------------------------------
`define NFC_REG_CTRL      8'h00
`define NFC_REG_FADDR     8'h04
`define NFC_REG_PARAM     8'h08
`define NFC_REG_STATUS    8'h0c
`define NFC_REG_GETDATA   8'h10
`define NFC_REG_UID_TOP   2'h1
`define NFC_PARAM_RST     32'h0000_0000
`define NFC_ST_BUSY       0
`define NFC_ST_DONE       1
`define NFC_ST_UID_OK     2
`define NFC_ST_UID_FAIL   3
`define NFC_ST_COPY_LSB   4
`define NFC_ST_READY      8
`endif

// ===== hdl/nfc_pkg.sv
package nfc_pkg;
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_UID  = 2'b01,
		OP_SET  = 2'b10,
		OP_GET  = 2'b11
	} nfc_op_type;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_WAITRDY = 4'b0001,
		ST_CMD     = 4'b0010,
		ST_ADDR    = 4'b0011,
		ST_ADL     = 4'b0100,
		ST_DIN     = 4'b0101,
		ST_WB      = 4'b0110,
		ST_BUSY    = 4'b0111,
		ST_RNDCMD  = 4'b1000,
		ST_RNDCOL  = 4'b1001,
		ST_RNDEND  = 4'b1010,
		ST_WHR     = 4'b1011,
		ST_DOUT    = 4'b1100,
		ST_DONE    = 4'b1101
	} nfc_state_type;
endpackage

// ===== hdl/nfc_id_mem.sv
`timescale 1ns/10ps
module nfc_id_mem #(
	parameter int DW = 8,
	parameter int AW = 4
) (
	input  wire logic          core_clk, // Clock
	input  wire logic          wrEn,     // Write strobe
	input  wire logic [AW-1:0] wrAddr,   // Write address
	input  wire logic [DW-1:0] wrData,   // Write data
	input  wire logic [AW-1:0] rdAddr,   // Read address
	output logic      [DW-1:0] rdData    // Registered read data
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge core_clk)
	begin
		if (wrEn)
		begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge core_clk)
	begin
		rdData <= mem[rdAddr];
	end
endmodule // nfc_id_mem

// ===== hdl/nfc_feature_ctrl.sv
`timescale 1ns/10ps
`include "nfc_cfg.svh"
module nfc_feature_ctrl import nfc_pkg::*; #(
	parameter int AXI_AW = 8
) (
	input  wire logic              core_clk, // 100 MHz clock
	input  wire logic              resetn,   // Async reset, active low
	input  wire logic [AXI_AW-1:0] awaddr,   // Write address
	input  wire logic              awvalid,  // Write address valid
	output logic                   awready,  // Write address ready
	input  wire logic [31:0]       wdata,    // Write data
	input  wire logic [3:0]        wstrb,    // Write byte strobes
	input  wire logic              wvalid,   // Write data valid
	output logic                   wready,   // Write data ready
	output logic [1:0]             bresp,    // Write response
	output logic                   bvalid,   // Write response valid
	input  wire logic              bready,   // Write response ready
	input  wire logic [AXI_AW-1:0] araddr,   // Read address
	input  wire logic              arvalid,  // Read address valid
	output logic                   arready,  // Read address ready
	output logic [31:0]            rdata,    // Read data
	output logic [1:0]             rresp,    // Read response
	output logic                   rvalid,   // Read data valid
	input  wire logic              rready,   // Read data ready
	output logic                   ceN,      // Chip enable, active low
	output logic                   cle,      // Command latch enable
	output logic                   ale,      // Address latch enable
	output logic                   weN,      // Write enable, active low
	output logic                   reN,      // Read enable, active low
	output logic [7:0]             ioOut,    // Data pins, driven value
	output logic                   ioOe,     // Data pins, drive enable
	input  wire logic [7:0]        ioIn,     // Data pins, sensed value
	input  wire logic              rbN       // Ready/busy, low while busy
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] selByte(input logic [31:0] w, input logic [1:0] i);
		selByte = w[8*i +: 8];
	endfunction

	function automatic logic [7:0] tmrFor(input nfc_state_type st, input logic ph);
		case (st)
			ST_CMD, ST_ADDR, ST_DIN, ST_RNDCMD, ST_RNDCOL, ST_RNDEND:
				tmrFor = ph ? `NFC_WH_CYC - 8'h01 : `NFC_WP_CYC - 8'h01;
			ST_DOUT: tmrFor = ph ? `NFC_REH_CYC - 8'h01 : `NFC_RP_CYC - 8'h01;
			ST_ADL:  tmrFor = `NFC_ADL_CYC - 8'h01;
			ST_WB:   tmrFor = `NFC_WB_CYC - 8'h01;
			ST_WHR:  tmrFor = `NFC_WHR_CYC - 8'h01;
			default: tmrFor = 8'h00;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------
	logic [7:0] ioMeta_r;
	logic [7:0] ioSync_r;
	logic       rbMeta_r;
	logic       rbSync_r;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ioMeta_r <= 8'h00;
			ioSync_r <= 8'h00;
			rbMeta_r <= 1'b0;
			rbSync_r <= 1'b0;
		end
		else
		begin
			ioMeta_r <= ioIn;
			ioSync_r <= ioMeta_r;
			rbMeta_r <= rbN;
			rbSync_r <= rbMeta_r;
		end
	end

	// ------------------------------------------------------------
	// Register bus slave
	// ------------------------------------------------------------
	nfc_state_type     state_r;
	nfc_op_type        op_r;
	logic [AXI_AW-1:0] awAddr_r;
	logic              awGot_r;
	logic [31:0]       wData_r;
	logic [3:0]        wStrb_r;
	logic              wGot_r;
	logic [AXI_AW-1:0] arAddr_r;
	logic              rStage_r;
	logic [7:0]        faddr_r;
	logic [31:0]       param_r;
	logic [3:0]        startCopy_r;
	logic [31:0]       getData_r;
	logic              done_r;
	logic              uidOk_r;
	logic              uidFail_r;
	logic [3:0]        copy_r;
	logic [7:0]        memRdata;
	logic              doWrite;
	logic              startReq;

	assign awready  = !awGot_r && !bvalid;
	assign wready   = !wGot_r && !bvalid;
	assign arready  = !rStage_r && !rvalid;
	assign doWrite  = awGot_r && wGot_r && !bvalid;
	// A start while an operation runs is dropped; the idle check keeps ops apart
	assign startReq = doWrite && awAddr_r[7:0] == `NFC_REG_CTRL && wStrb_r[0]
		&& wData_r[1:0] != OP_NONE && state_r == ST_IDLE;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			awGot_r  <= 1'b0;
			awAddr_r <= '0;
			wGot_r   <= 1'b0;
			wData_r  <= 32'h0000_0000;
			wStrb_r  <= 4'h0;
			bvalid   <= 1'b0;
			bresp    <= 2'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awGot_r  <= 1'b1;
				awAddr_r <= awaddr;
			end
			if (wvalid && wready)
			begin
				wGot_r  <= 1'b1;
				wData_r <= wdata;
				wStrb_r <= wstrb;
			end
			if (doWrite)
			begin
				awGot_r <= 1'b0;
				wGot_r  <= 1'b0;
				bvalid  <= 1'b1;
				case (awAddr_r[7:0])
					`NFC_REG_CTRL, `NFC_REG_FADDR, `NFC_REG_PARAM: bresp <= 2'h0;
					default: bresp <= 2'h2;
				endcase
			end
			else if (bvalid && bready)
			begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			op_r        <= OP_NONE;
			startCopy_r <= 4'h0;
			faddr_r     <= 8'h00;
			param_r     <= `NFC_PARAM_RST;
		end
		else if (doWrite)
		begin
			if (startReq)
			begin
				op_r        <= nfc_op_type'(wData_r[1:0]);
				startCopy_r <= wData_r[7:4];
			end
			if (awAddr_r[7:0] == `NFC_REG_FADDR && wStrb_r[0])
			begin
				faddr_r <= wData_r[7:0];
			end
			if (awAddr_r[7:0] == `NFC_REG_PARAM)
			begin
				for (int i = 0; i < 4; i++)
				begin
					if (wStrb_r[i])
					begin
						param_r[8*i +: 8] <= wData_r[8*i +: 8];
					end
				end
			end
		end
	end

	// Read takes two edges so the ID memory can answer from its register
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			arAddr_r <= '0;
			rStage_r <= 1'b0;
			rvalid   <= 1'b0;
			rdata    <= 32'h0000_0000;
			rresp    <= 2'h0;
		end
		else
		begin
			if (arvalid && arready)
			begin
				arAddr_r <= araddr;
				rStage_r <= 1'b1;
			end
			else if (rStage_r)
			begin
				rStage_r <= 1'b0;
				rvalid   <= 1'b1;
				rresp    <= 2'h0;
				if (arAddr_r[7:6] == `NFC_REG_UID_TOP)
				begin
					rdata <= {24'h000000, memRdata};
				end
				else
				begin
					case (arAddr_r[7:0])
						`NFC_REG_CTRL:    rdata <= {24'h000000, startCopy_r, 2'b00, op_r};
						`NFC_REG_FADDR:   rdata <= {24'h000000, faddr_r};
						`NFC_REG_PARAM:   rdata <= param_r;
						`NFC_REG_STATUS:  rdata <= {23'h000000, rbSync_r, copy_r, uidFail_r,
							uidOk_r, done_r, state_r != ST_IDLE};
						`NFC_REG_GETDATA: rdata <= getData_r;
						default:
						begin
							rdata <= 32'h0000_0000;
							rresp <= 2'h2;
						end
					endcase
				end
			end
			else if (rvalid && rready)
			begin
				rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	nfc_state_type state_nxt;
	logic          phase_r;
	logic          phase_nxt;
	logic [7:0]    tmr_r;
	logic [4:0]    cnt_r;
	logic [4:0]    cnt_nxt;
	logic          ok_r;
	logic          capture;
	logic          finOk;
	logic          finFail;
	logic          nextCopy;
	logic          isWr;
	logic [7:0]    curByte;

	assign isWr    = state_r inside {ST_CMD, ST_ADDR, ST_DIN, ST_RNDCMD, ST_RNDCOL, ST_RNDEND};
	assign capture = state_r == ST_DOUT && !phase_r && tmr_r == 8'h00; // see RL5

	always_comb
	begin
		case (state_r)
			ST_CMD:    curByte = op_r == OP_UID ? `NFC_CODE_UID :            // see RL2
				(op_r == OP_SET ? `NFC_CODE_SET : `NFC_CODE_GET);           // see RL16
			ST_ADDR:   curByte = op_r == OP_UID ? `NFC_UID_ADDR : faddr_r;  // see RL3
			ST_DIN:    curByte = selByte(param_r, cnt_r[1:0]);              // see RL10 RL12
			ST_RNDCMD: curByte = `NFC_CODE_RND1;
			ST_RNDCOL: curByte = cnt_r[0] ? {7'h00, copy_r[3]} : {copy_r[2:0], 5'h00};
			ST_RNDEND: curByte = `NFC_CODE_RND2;
			default:   curByte = 8'h00;
		endcase
	end

	always_comb
	begin
		state_nxt = state_r;
		phase_nxt = phase_r;
		cnt_nxt   = cnt_r;
		finOk     = 1'b0;
		finFail   = 1'b0;
		nextCopy  = 1'b0;
		case (state_r)
			ST_IDLE:
				if (startReq)
				begin
					state_nxt = ST_WAITRDY;
				end
			ST_WAITRDY:
				if (rbSync_r) // see RL1
				begin
					state_nxt = ST_CMD;
				end
			ST_CMD, ST_ADDR, ST_DIN, ST_RNDCMD, ST_RNDCOL, ST_RNDEND:
				if (tmr_r == 8'h00)
				begin
					phase_nxt = !phase_r;
					if (phase_r)
					begin
						cnt_nxt = 5'h00;
						case (state_r)
							ST_CMD:    state_nxt = ST_ADDR;
							ST_ADDR:   state_nxt = op_r == OP_SET ? ST_ADL : ST_WB; // see RL20
							ST_DIN:
								if (cnt_r == 5'h03)
								begin
									state_nxt = ST_WB; // see RL18
								end
								else
								begin
									cnt_nxt = cnt_r + 5'h01; // see RL17
								end
							ST_RNDCMD: state_nxt = ST_RNDCOL;
							ST_RNDCOL:
								if (cnt_r[0])
								begin
									state_nxt = ST_RNDEND;
								end
								else
								begin
									cnt_nxt = 5'h01;
								end
							default:   state_nxt = ST_WHR;
						endcase
					end
				end
			ST_ADL:
				if (tmr_r == 8'h00) // see RL17
				begin
					state_nxt = ST_DIN;
				end
			ST_WB:
				if (tmr_r == 8'h00)
				begin
					state_nxt = ST_BUSY;
				end
			ST_BUSY:
				// Ready/busy covers tR, tFEAT and tITC, so no 70h/78h polling; see RL4 RL21
				if (rbSync_r) // see RL24
				begin
					if (op_r == OP_SET)
					begin
						state_nxt = ST_DONE; // see RL19
					end
					else if (op_r == OP_UID && copy_r != 4'h0)
					begin
						state_nxt = ST_RNDCMD; // see RL8
					end
					else
					begin
						state_nxt = ST_WHR; // see RL22
					end
				end
			ST_WHR:
				if (tmr_r == 8'h00)
				begin
					state_nxt = ST_DOUT;
				end
			ST_DOUT:
				if (tmr_r == 8'h00)
				begin
					phase_nxt = !phase_r;
					if (phase_r)
					begin
						cnt_nxt = cnt_r + 5'h01;
						if (op_r == OP_GET && cnt_r == 5'h03) // see RL23
						begin
							state_nxt = ST_DONE;
						end
						else if (op_r == OP_UID && cnt_r == `NFC_LAST_BYTE) // see RL6
						begin
							cnt_nxt = 5'h00;
							if (ok_r) // see RL7
							begin
								state_nxt = ST_DONE;
								finOk     = 1'b1;
							end
							else if (copy_r == 4'hf)
							begin
								state_nxt = ST_DONE;
								finFail   = 1'b1;
							end
							else
							begin
								nextCopy = 1'b1;
							end
						end
					end
				end
			ST_DONE:   state_nxt = ST_IDLE;
			default:   state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= ST_IDLE;
			phase_r <= 1'b0;
			cnt_r   <= 5'h00;
			tmr_r   <= 8'h00;
		end
		else
		begin
			state_r <= state_nxt;
			phase_r <= phase_nxt;
			cnt_r   <= cnt_nxt;
			if (state_nxt != state_r || phase_nxt != phase_r)
			begin
				tmr_r <= tmrFor(state_nxt, phase_nxt);
			end
			else if (tmr_r != 8'h00)
			begin
				tmr_r <= tmr_r - 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Results
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			copy_r    <= 4'h0;
			ok_r      <= 1'b0;
			done_r    <= 1'b0;
			uidOk_r   <= 1'b0;
			uidFail_r <= 1'b0;
			getData_r <= 32'h0000_0000;
		end
		else
		begin
			if (startReq)
			begin
				copy_r    <= wData_r[7:4];
				done_r    <= 1'b0;
				uidOk_r   <= 1'b0;
				uidFail_r <= 1'b0;
			end
			else if (state_r == ST_DONE)
			begin
				done_r <= 1'b1;
			end
			if (nextCopy)
			begin
				copy_r <= copy_r + 4'h1;
			end
			if (finOk)
			begin
				uidOk_r <= 1'b1;
			end
			if (finFail)
			begin
				uidFail_r <= 1'b1;
			end
			if (capture && op_r == OP_GET)
			begin
				getData_r[8*cnt_r[1:0] +: 8] <= ioSync_r; // see RL23
			end
			if (capture && op_r == OP_UID)
			begin
				if (cnt_r == 5'h00)
				begin
					ok_r <= 1'b1;
				end
				else if (cnt_r >= `NFC_HALF_BYTES)
				begin
					ok_r <= ok_r && ((memRdata ^ ioSync_r) == 8'hff); // see RL7
				end
			end
		end
	end

	// First half of each copy lands here; the second half is checked against it
	nfc_id_mem #(
		.DW(8),
		.AW(4)
	) uIdMem (
		.core_clk(core_clk),
		.wrEn    (capture && op_r == OP_UID && cnt_r < `NFC_HALF_BYTES), // see RL6
		.wrAddr  (cnt_r[3:0]),
		.wrData  (ioSync_r),
		.rdAddr  (state_r == ST_DOUT ? cnt_r[3:0] : araddr[5:2]),
		.rdData  (memRdata)
	);

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ceN   <= 1'b1;
			cle   <= 1'b0;
			ale   <= 1'b0;
			weN   <= 1'b1;
			reN   <= 1'b1;
			ioOut <= 8'h00;
			ioOe  <= 1'b0;
		end
		else
		begin
			ceN   <= state_r == ST_IDLE;
			cle   <= state_r inside {ST_CMD, ST_RNDCMD, ST_RNDEND};
			ale   <= state_r inside {ST_ADDR, ST_RNDCOL};
			weN   <= !(isWr && !phase_r);
			reN   <= !(state_r == ST_DOUT && !phase_r);
			ioOut <= curByte;
			ioOe  <= isWr;
		end
	end
endmodule // nfc_feature_ctrl

// ===== dv/nfc_feature_ctrl_properties.sv
`timescale 1ns/10ps
module nfc_feature_ctrl_properties (
	input wire logic        core_clk, // Clock
	input wire logic        resetn,   // Reset
	input wire logic        bvalid,   // Write resp
	input wire logic        bready,   // Resp taken
	input wire logic [1:0]  bresp,    // Resp code
	input wire logic        arvalid,  // Read request
	input wire logic        arready,  // Request taken
	input wire logic        rvalid,   // Read resp
	input wire logic        rready,   // Resp taken
	input wire logic [31:0] rdata,    // Read word
	input wire logic        ceN,      // Chip enable
	input wire logic        cle,      // Command byte
	input wire logic        ale,      // Address byte
	input wire logic        weN,      // Write strobe
	input wire logic        reN,      // Read strobe
	input wire logic [7:0]  ioOut,    // Host byte
	input wire logic        ioOe,     // Host drives
	input wire logic        rbN       // Ready/busy
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	// ----------------
	// Helper
	// ----------------
	logic [7:0] lastCmd_r;

	// Address checks need to know which command they follow
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			lastCmd_r <= 8'h00;
		else if (!weN && cle)
			lastCmd_r <= ioOut;
	end

	// ----------------
	// Properties
	// ----------------
	a_no_status_cmd: assert property (
		!weN && cle |-> !(ioOut inside {8'h70, 8'h78}))
		else $error("status command issued");
	a_uid_addr_zero: assert property (
		!weN && ale && lastCmd_r == 8'hed |-> ioOut == 8'h00)
		else $error("unique id address not zero");
	a_adl_gap_held: assert property (
		$rose(weN) && ale && lastCmd_r == 8'hef |-> weN[*8] ##1 weN[*2])
		else $error("parameter sent too soon after address");
	a_quiet_when_busy: assert property (!rbN |-> reN && weN)
		else $error("strobe while target busy");
	a_write_strobe_shape: assert property ($fell(weN) |-> !weN[*2] ##1 weN)
		else $error("write strobe width wrong");
	a_write_drives_bus: assert property (!weN |-> ioOe && !ceN)
		else $error("write without driving bus");
	a_read_bus_free: assert property (!reN |-> !ioOe && !ceN && !cle && !ale)
		else $error("read while bus driven");
	a_read_answer_time: assert property (arvalid && arready |-> ##[2:3] rvalid)
		else $error("read answer late");
	a_bresp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");

	c_read_byte: cover property ($fell(reN));
	c_target_busy: cover property (!rbN);
	c_write_err: cover property (bvalid && bready && bresp == 2'h2);
endmodule // nfc_feature_ctrl_properties

// ===== dv/nfc_nand_model.sv
`timescale 1ns/10ps
module nfc_nand_model (
	input wire logic        ceN,      // Chip enable
	input wire logic        cle,      // Command byte
	input wire logic        ale,      // Address byte
	input wire logic        weN,      // Write strobe
	input wire logic        reN,      // Read strobe
	input wire logic [7:0]  ioOut,    // Host byte
	input wire logic        slowBusy, // Long busy
	input wire logic [15:0] badMask,  // Corrupt copies
	output logic     [7:0]  dq,       // Device byte
	output logic            rbN       // Ready/busy
);
	logic [7:0] cmd_r, mode_r, p1_r;
	logic [8:0] ptr_r, col_r;
	logic [2:0] fi_r;
	logic [1:0] cnt_r;
	logic [7:0] feat_r [4];

	// Marked copies get bit 0 flipped in each complement byte so the host check must reject them
	function automatic logic [7:0] uidByte(input logic [8:0] p);
		logic [7:0] v;
		v = 8'ha0 + {4'h0, p[3:0]};
		if (p[4])
			v = ~v ^ {7'h0, badMask[p[8:5]]};
		return v;
	endfunction

	task automatic goBusy();
		rbN = 1'b0;
		#(slowBusy ? 3000 : 300);
		rbN = 1'b1;
	endtask

	initial
	begin
		rbN = 1'b1;
		dq = 8'h00;
		mode_r = 8'h00;
		cmd_r = 8'h00;
		fi_r = 3'd4;
		for (int i = 0; i < 4; i++)
			feat_r[i] = 8'h00;
	end

	always @(posedge weN)
	begin
		if (!ceN && rbN)
		begin
			if (cle)
			begin
				cmd_r = ioOut;
				cnt_r = 2'd0;
				if (ioOut inside {8'hed, 8'hef, 8'hee})
					mode_r = ioOut;
				if (ioOut == 8'he0)
					ptr_r = col_r;
			end
			else if (ale && cmd_r == 8'h05)
			begin
				col_r = cnt_r[0] ? {ioOut[0], col_r[7:0]} : {1'b0, ioOut};
				cnt_r++;
			end
			else if (ale)
			begin
				case (ioOut)
					8'h01: fi_r = 3'd0;
					8'h80: fi_r = 3'd1;
					8'h81: fi_r = 3'd2;
					8'h90: fi_r = 3'd3;
					default: fi_r = 3'd4;
				endcase
				ptr_r = 9'd0;
				if (cmd_r != 8'hef)
					goBusy();
			end
			else if (cmd_r == 8'hef)
			begin
				if (cnt_r == 2'd0)
					p1_r = ioOut;
				cnt_r++;
				if (cnt_r == 2'd0 && fi_r < 3'd4)
					feat_r[fi_r[1:0]] = p1_r;
				if (cnt_r == 2'd0)
					goBusy();
			end
		end
	end

	always @(negedge reN)
	begin
		if (!ceN)
		begin
			if (mode_r == 8'hed)
				dq = uidByte(ptr_r);
			else
				dq = (ptr_r == 9'd0 && fi_r < 3'd4) ? feat_r[fi_r[1:0]] : 8'h00;
			ptr_r++;
		end
	end

	// Released bus shows the inverse of the last byte
	always @(posedge reN)
		dq = ~dq;
endmodule // nfc_nand_model

// ===== dv/test_nfc_feature_ctrl.sv
`timescale 1ns/10ps
module test_nfc_feature_ctrl;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, slowBusy = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        ceN, cle, ale, weN, reN, ioOe, rbN;
	logic [1:0]  bresp, rresp, rs;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ioOut, dq, ioIn;
	logic [15:0] badMask = 16'h0000;
	logic [31:0] wdata = 32'h0, rdata, d;
	int          miscompares = 0, testsRun = 0;

	assign ioIn = ioOe ? ioOut : dq;
	always #5 core_clk = ~core_clk;

	nfc_feature_ctrl i_nfc_feature_ctrl (
		.core_clk(core_clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .ceN(ceN), .cle(cle), .ale(ale), .weN(weN),
		.reN(reN), .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn), .rbN(rbN)
	);
	nfc_nand_model i_nfc_nand_model (
		.ceN(ceN), .cle(cle), .ale(ale), .weN(weN), .reN(reN), .ioOut(ioOut),
		.slowBusy(slowBusy), .badMask(badMask), .dq(dq), .rbN(rbN)
	);

	// ----------------
	// Helpers
	// ----------------
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic hang();
		chk(32'h1, 32'h0);
		summarize();
	endtask

	// Handshakes are judged at the falling edge, where ready has settled
	task automatic axi(input logic wr, input logic [7:0] a, inout logic [31:0] v);
		logic aw, w, ar, done;
		done = 1'b0;
		@(posedge core_clk);
		awaddr <= a;
		araddr <= a;
		wdata <= v;
		awvalid <= wr;
		wvalid <= wr;
		bready <= wr;
		arvalid <= !wr;
		rready <= !wr;
		for (int n = 0; !done; n++)
		begin
			@(negedge core_clk);
			aw = awvalid && awready;
			w = wvalid && wready;
			ar = arvalid && arready;
			done = wr ? bvalid === 1'b1 : rvalid === 1'b1;
			rs = wr ? bresp : rresp;
			v = wr ? v : rdata;
			@(posedge core_clk);
			awvalid <= awvalid && !aw;
			wvalid <= wvalid && !w;
			arvalid <= arvalid && !ar;
			bready <= bready && !done;
			rready <= rready && !done;
			if (n > 200)
				hang();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		axi(1'b1, a, v);
		chk({30'h0, rs}, {30'h0, er});
	endtask

	task automatic run_op(input logic [31:0] c);
		wr(8'h00, c, 2'h0);
		d = 32'h0;
		for (int n = 0; d[1] !== 1'b1; n++)
		begin
			axi(1'b0, 8'h0c, d);
			if (n > 3000)
				hang();
		end
	endtask

	task automatic get_feat(input logic [7:0] a, input logic [7:0] p);
		wr(8'h04, {24'h0, a}, 2'h0);
		run_op(32'h3);
		axi(1'b0, 8'h10, d);
		chk(d, {24'h0, p});
	endtask

	// ----------------
	// Scenarios
	// ----------------
	task automatic t_regs();
		logic [7:0] fa [5] = '{8'h00, 8'h01, 8'h80, 8'h81, 8'h90};
		axi(1'b0, 8'h0c, d);
		chk({29'h0, d[8], d[1:0]}, 32'h4);
		axi(1'b0, 8'h20, d);
		chk({rs, d[29:0]}, 32'h8000_0000);
		wr(8'h24, 32'h1, 2'h2);
		for (int i = 0; i < 5; i++)
			get_feat(fa[i], 8'h00);
		$display("t_regs done");
	endtask

	task automatic t_feat();
		logic [7:0] fa [8] = '{8'h01, 8'h80, 8'h81, 8'h90, 8'h90, 8'h90, 8'h40, 8'h90};
		logic [7:0] pv [8] = '{8'h05, 8'h03, 8'h02, 8'h01, 8'h03, 8'h08, 8'h77, 8'h00};
		for (int i = 0; i < 8; i++)
		begin
			slowBusy <= i[0];
			wr(8'h04, {24'h0, fa[i]}, 2'h0);
			wr(8'h08, {24'h5a5a5a, pv[i]}, 2'h0);
			run_op(32'h2);
			get_feat(fa[i], fa[i] == 8'h40 ? 8'h00 : pv[i]);
		end
		slowBusy <= 1'b0;
		$display("t_feat done");
	endtask

	task automatic t_uid(input logic [15:0] m, input logic [3:0] c, input logic [3:0] ec,
		input logic ok);
		badMask <= m;
		run_op({24'h0, c, 4'h1});
		chk({30'h0, d[3:2]}, {30'h0, !ok, ok});
		if (ok)
		begin
			chk({28'h0, d[7:4]}, {28'h0, ec});
			for (int i = 0; i < 16; i++)
			begin
				axi(1'b0, 8'h40 + 8'(4 * i), d);
				chk({24'h0, d[7:0]}, 32'ha0 + i);
			end
		end
		$display("t_uid done");
	endtask

	task automatic t_persist();
		wr(8'h04, 32'h90, 2'h0);
		wr(8'h08, 32'h8, 2'h0);
		run_op(32'h2);
		run_op(32'h1);
		get_feat(8'h90, 8'h08);
		$display("t_persist done");
	endtask

	// ----------------
	// Main
	// ----------------
	initial
	begin
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		t_regs();
		t_feat();
		t_uid(16'h0000, 4'h0, 4'h0, 1'b1);
		t_uid(16'h0007, 4'h0, 4'h3, 1'b1);
		t_uid(16'h0001, 4'h5, 4'h5, 1'b1);
		t_uid(16'hc000, 4'he, 4'h0, 1'b0);
		t_persist();
		summarize();
	end
endmodule // test_nfc_feature_ctrl

bind nfc_feature_ctrl nfc_feature_ctrl_properties i_nfc_feature_ctrl_properties (
	.core_clk(core_clk), .resetn(resetn), .bvalid(bvalid), .bready(bready),
	.bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
	.rready(rready), .rdata(rdata), .ceN(ceN), .cle(cle), .ale(ale), .weN(weN),
	.reN(reN), .ioOut(ioOut), .ioOe(ioOe), .rbN(rbN)
);
